// ---- swc_pkg.sv ----
/*
 * Constants, register map and state type for the sleep/wake controller.
 * Assumes a 20 MHz system clock and a 32-bit AHB-Lite register bus.
 */
package swc_pkg;

   localparam int CLK_PERIOD_NS = 50;

   // Register byte offsets on the AHB-Lite bus.
   localparam logic [7:0] ADDR_REGCTRL = 8'h00;
   localparam logic [7:0] ADDR_WDTCTRL = 8'h04;
   localparam logic [7:0] ADDR_STATUS  = 8'h08;

   // Regulator control fields.
   localparam int REGCTRL_PM_BIT  = 1;
   localparam int REGCTRL_RSV_BIT = 0;

   // Watchdog control fields: period select in bits 5:1, enable in bit 0.
   localparam int         WDT_PS_LSB    = 1;
   localparam int         WDT_PS_MSB    = 5;
   localparam int         WDT_EN_BIT    = 0;
   localparam logic [4:0] WDT_PS_RESET  = 5'h0b;
   localparam logic [4:0] WDT_PS_MAX    = 5'h12;
   localparam logic [4:0] WDT_BASE_SH   = 5'h05;
   localparam int         WDT_CNT_W     = 24;

   // Watchdog operating modes.
   localparam logic [1:0] WDT_MODE_OFF   = 2'h0;
   localparam logic [1:0] WDT_MODE_SW    = 2'h1;
   localparam logic [1:0] WDT_MODE_NOSLP = 2'h2;
   localparam logic [1:0] WDT_MODE_ON    = 2'h3;

   // Status register bit positions.
   localparam int STAT_TO_BIT  = 0;
   localparam int STAT_PD_BIT  = 1;
   localparam int STAT_SLP_BIT = 2;
   localparam int STAT_LP_BIT  = 3;
   localparam int STAT_CLK_BIT = 4;

   // Oscillator start-up: 1024 oscillator periods.
   localparam int OST_PERIODS = 1024;
   localparam int DLY_W       = 11;

   // Interrupt vector address.
   localparam logic [13:0] ISR_VECTOR = 14'h0004;

   typedef enum logic [1:0] {
      ST_AWAKE,
      ST_SLEEP,
      ST_OST,
      ST_LPWAIT
   } swc_state_t;

endpackage : swc_pkg

// ---- swc_sleep_wake_control.sv ----
/*
 * Sleep/wake controller: sleep entry, wake sources, status flags,
 * regulator sleep mode, start-up delays and the watchdog counter.
 * Assumes all inputs are synchronous to mclk_i and that wdt_tick_i is a
 * one-cycle pulse per period of the low-frequency watchdog oscillator.
 */
// The register addresses and the AHB-Lite slave port were chosen for this implementation.
// Summary of operation
// - Sleep entered only by sleep instruction
// - Entry: clear PD, set TO, stop clock
// - Five wake events, pin and brown-out ones gated
// - Pin, brown-out, power-on wake resets device
// - Prefetch next address during sleep instruction
// - Enabled interrupts wake, global enable ignored
// - Resume in line, vector 0004h if enabled
// - Watchdog cleared on every wake
// - Pending enabled interrupt makes sleep no-op if global enable clear
// - Late interrupt: complete sleep, wake at once
// - Crystal wake waits 1024 oscillator periods unless two-speed start-up is on
// - Mode bit selects low-power regulator sleep
// - Low-power sleep adds wake stabilisation delay
// - Incompatible peripheral keeps regulator normal
// - Waveform unit may keep HF oscillator running
// - Control bit 0 reads one, bit 1 mode, rest zero
// - Unregulated variant: lowest power, no delay
// - Watchdog resets unless cleared in time
// - Period 1 ms to 256 s, own clock
// - Four watchdog modes
module swc_sleep_wake_control #(
   parameter int LP_WAKE_NS = 5000
) (
   input  wire logic                       mclk_i,
   input  wire logic                       reset_i,
   input  wire logic                       hsel_i,
   input  wire logic [31:0]                haddr_i,
   input  wire logic [1:0]                 htrans_i,
   input  wire logic                       hwrite_i,
   input  wire logic [2:0]                 hsize_i,
   input  wire logic [31:0]                hwdata_i,
   input  wire logic                       hready_i,
   output logic      [31:0]                hrdata_o,
   output logic                            hreadyout_o,
   output logic                            hresp_o,
   input  wire logic                       sleep_instr_i,
   input  wire logic                       watchdog_clear_instruction_instr_i,
   input  wire logic                       global_interrupt_enable_i,
   input  wire logic [7:0]                 irq_flag_i,
   input  wire logic [7:0]                 irq_enable_i,
   input  wire logic                       external_reset_pin_i,
   input  wire logic                       external_reset_en_i,
   input  wire logic                       brownout_reset_i,
   input  wire logic                       brownout_reset_en_i,
   input  wire logic                       por_i,
   input  wire logic [1:0]                 wdt_mode_i,
   input  wire logic                       wdt_tick_i,
   input  wire logic                       crystal_osc_mode_i,
   input  wire logic                       two_speed_i,
   input  wire logic                       lp_incompatible_i,
   input  wire logic                       unregulated_i,
   input  wire logic                       cwu_uses_hfosc_i,
   output logic                            cpu_clk_en_o,
   output logic                            device_reset_o,
   output logic                            timeout_status_flag_o,
   output logic                            powerdown_status_flag_o,
   output logic                            prefetch_next_o,
   output logic                            resume_o,
   output logic                            vector_req_o,
   output logic      [13:0]                vector_addr_o,
   output logic                            reg_lowpower_o,
   output logic                            hfosc_keep_o,
   output logic                            sleeping_o
);
   import swc_pkg::*;

   localparam int LP_WAKE_CYC =
      (LP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [DLY_W-1:0] OST_CNT = DLY_W'(OST_PERIODS - 1);
   localparam logic [DLY_W-1:0] LP_CNT  =
      DLY_W'(LP_WAKE_CYC < 1 ? 0 : LP_WAKE_CYC - 1);

   function automatic logic [1:0] reg_index(input logic [7:0] a);
      case (a)
         ADDR_REGCTRL: reg_index = 2'h1;
         ADDR_WDTCTRL: reg_index = 2'h2;
         ADDR_STATUS:  reg_index = 2'h3;
         default:      reg_index = 2'h0;
      endcase
   endfunction

   swc_state_t             state_reg;
   logic [DLY_W-1:0]       dly_reg;
   logic                   to_reg;
   logic                   pd_reg;
   logic                   pm_reg;
   logic [4:0]             wdt_ps_reg;
   logic                   wdt_sw_en_reg;
   logic [WDT_CNT_W-1:0]   wdt_cnt_reg;
   logic                   wr_pend_reg;
   logic [7:0]             wr_addr_reg;
   logic                   rst_out_reg;
   logic                   prefetch_reg;
   logic                   resume_reg;
   logic                   vec_reg;
   logic [13:0]            vec_addr_reg;

   logic                   irq_pending;
   logic                   reset_event;
   logic                   sleep_nop;
   logic                   sleep_enter;
   logic                   wdt_active;
   logic                   wdt_expire;
   logic                   wdt_clear;
   logic                   wake_evt;
   logic                   lp_eff;
   logic                   leaving_sleep;
   logic [WDT_CNT_W-1:0]   wdt_limit;
   logic                   bus_take;
   logic [31:0]            rd_mux;

   assign irq_pending = |(irq_flag_i & irq_enable_i);

   assign reset_event = por_i
                      | (external_reset_pin_i & external_reset_en_i)
                      | (brownout_reset_i & brownout_reset_en_i);

   assign sleep_nop = sleep_instr_i & ~global_interrupt_enable_i
                    & irq_pending;

   assign sleep_enter = (state_reg == ST_AWAKE) & sleep_instr_i
                      & ~sleep_nop;

   always_comb begin
      case (wdt_mode_i)
         WDT_MODE_ON:    wdt_active = 1'b1;
         WDT_MODE_NOSLP: wdt_active = (state_reg == ST_AWAKE);
         WDT_MODE_SW:    wdt_active = wdt_sw_en_reg;
         default:        wdt_active = 1'b0;
      endcase
   end

   // period 1 ms to 256 s
   always_comb begin
      if (wdt_ps_reg > WDT_PS_MAX) begin
         wdt_limit = WDT_CNT_W'(1) << WDT_BASE_SH;
      end else begin
         wdt_limit = WDT_CNT_W'(1) << (wdt_ps_reg + WDT_BASE_SH);
      end
   end

   assign wdt_expire = wdt_active & wdt_tick_i
                     & (wdt_cnt_reg == wdt_limit - WDT_CNT_W'(1));

   assign wake_evt = (state_reg == ST_SLEEP)
                   & (irq_pending | wdt_expire);
   assign leaving_sleep = wake_evt & ~reset_event;

   assign lp_eff = pm_reg & ~lp_incompatible_i & ~unregulated_i;

   assign wdt_clear = reset_event | watchdog_clear_instruction_instr_i | sleep_enter
                    | leaving_sleep | ~wdt_active
                    | (state_reg == ST_OST);

   // Sleep state machine: entry, wake and the start-up delays.
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         state_reg <= ST_AWAKE;
         dly_reg   <= '0;
      end else if (reset_event) begin
         state_reg <= ST_AWAKE;
         dly_reg   <= '0;
      end else begin
         case (state_reg)
            ST_AWAKE: begin
               if (sleep_enter) begin
                  state_reg <= ST_SLEEP;
               end
            end
            ST_SLEEP: begin
               if (wake_evt) begin
                  if (crystal_osc_mode_i & ~two_speed_i) begin
                     state_reg <= ST_OST;
                     dly_reg   <= OST_CNT;
                  end else if (lp_eff) begin
                     state_reg <= ST_LPWAIT;
                     dly_reg   <= LP_CNT;
                  end else begin
                     state_reg <= ST_AWAKE;
                  end
               end
            end
            ST_OST: begin
               if (dly_reg != '0) begin
                  dly_reg <= dly_reg - DLY_W'(1);
               end else if (lp_eff) begin
                  state_reg <= ST_LPWAIT;
                  dly_reg   <= LP_CNT;
               end else begin
                  state_reg <= ST_AWAKE;
               end
            end
            ST_LPWAIT: begin
               if (dly_reg != '0) begin
                  dly_reg <= dly_reg - DLY_W'(1);
               end else begin
                  state_reg <= ST_AWAKE;
               end
            end
            default: begin
               state_reg <= ST_AWAKE;
            end
         endcase
      end
   end

   // Status flags. Reset events win over a watchdog time-out, which wins
   // over sleep entry and the clear instruction.
   always_ff @(posedge mclk_i) begin
      if (reset_i || reset_event) begin
         to_reg <= 1'b1;
         pd_reg <= 1'b1;
      end else if (wdt_expire) begin
         to_reg <= 1'b0;
         pd_reg <= (state_reg == ST_AWAKE);
      end else if (sleep_enter) begin
         to_reg <= 1'b1;
         pd_reg <= 1'b0;
      end else if (watchdog_clear_instruction_instr_i) begin
         to_reg <= 1'b1;
         pd_reg <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || wdt_clear || wdt_expire) begin
         wdt_cnt_reg <= '0;
      end else if (wdt_tick_i) begin
         wdt_cnt_reg <= wdt_cnt_reg + WDT_CNT_W'(1);
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         rst_out_reg <= 1'b0;
      end else begin
         rst_out_reg <= reset_event
                      | (wdt_expire & (state_reg == ST_AWAKE));
      end
   end

   // Core hand-shake pulses: prefetch, resume and vector request.
   always_ff @(posedge mclk_i) begin
      if (reset_i || reset_event) begin
         prefetch_reg <= 1'b0;
         resume_reg   <= 1'b0;
         vec_reg      <= 1'b0;
         vec_addr_reg <= '0;
      end else begin
         prefetch_reg <= sleep_instr_i & (state_reg == ST_AWAKE);
         resume_reg   <= (state_reg != ST_AWAKE)
                       & (state_reg != ST_SLEEP | leaving_sleep)
                       & (state_reg == ST_SLEEP ? ~
                          ((crystal_osc_mode_i & ~two_speed_i) | lp_eff)
                          : (dly_reg == '0)
                            & ~(state_reg == ST_OST & lp_eff));
         vec_reg      <= 1'b0;
         if (resume_reg) begin
            vec_reg      <= global_interrupt_enable_i;
            vec_addr_reg <= ISR_VECTOR;
         end
      end
   end

   // AHB-Lite slave: zero wait states, always OKAY.
   assign bus_take = hsel_i & htrans_i[1] & hready_i;

   always_comb begin
      rd_mux = '0;
      case (reg_index(haddr_i[7:0]))
         2'h1: begin
            rd_mux[REGCTRL_RSV_BIT] = 1'b1;
            rd_mux[REGCTRL_PM_BIT]  = pm_reg;
         end
         2'h2: begin
            rd_mux[WDT_PS_MSB:WDT_PS_LSB] = wdt_ps_reg;
            rd_mux[WDT_EN_BIT]            = wdt_sw_en_reg;
         end
         2'h3: begin
            rd_mux[STAT_TO_BIT]  = to_reg;
            rd_mux[STAT_PD_BIT]  = pd_reg;
            rd_mux[STAT_SLP_BIT] = (state_reg == ST_SLEEP);
            rd_mux[STAT_LP_BIT]  = reg_lowpower_o;
            rd_mux[STAT_CLK_BIT] = (state_reg == ST_AWAKE);
         end
         default: begin
            rd_mux = '0;
         end
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata_o    <= '0;
      end else begin
         if (hready_i) begin
            wr_pend_reg <= bus_take & hwrite_i;
            wr_addr_reg <= haddr_i[7:0];
         end
         if (bus_take & ~hwrite_i) begin
            hrdata_o <= rd_mux;
         end
      end
   end

   // Software registers, written in the data phase.
   always_ff @(posedge mclk_i) begin
      if (reset_i || reset_event) begin
         pm_reg        <= 1'b0;
         wdt_ps_reg    <= WDT_PS_RESET;
         wdt_sw_en_reg <= 1'b0;
      end else if (wr_pend_reg) begin
         case (reg_index(wr_addr_reg))
            2'h1: begin
               pm_reg <= hwdata_i[REGCTRL_PM_BIT];
            end
            2'h2: begin
               wdt_ps_reg    <= hwdata_i[WDT_PS_MSB:WDT_PS_LSB];
               wdt_sw_en_reg <= hwdata_i[WDT_EN_BIT];
            end
            default: begin
               pm_reg <= pm_reg;
            end
         endcase
      end
   end

   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   assign cpu_clk_en_o = (state_reg == ST_AWAKE);
   assign sleeping_o   = (state_reg == ST_SLEEP);

   assign reg_lowpower_o = sleeping_o & (lp_eff | unregulated_i);

   // HF oscillator kept for waveform unit
   assign hfosc_keep_o = sleeping_o & cwu_uses_hfosc_i;

   assign device_reset_o          = rst_out_reg;
   assign timeout_status_flag_o   = to_reg;
   assign powerdown_status_flag_o = pd_reg;
   assign prefetch_next_o         = prefetch_reg;
   assign resume_o                = resume_reg;
   assign vector_req_o            = vec_reg;
   assign vector_addr_o           = vec_addr_reg;

endmodule // swc_sleep_wake_control

// ---- swc_chk.sv ----
/* Assertions on the ports of the sleep/wake controller.
   Assumes one clock, mclk_i, and a synchronous active-high reset. */
module swc_chk
   import swc_pkg::*;
#(
   parameter int LP_WAKE_NS = 5000
) (
   input wire logic        mclk_i,
   input wire logic        reset_i,
   input wire logic        sleep_instr_i,
   input wire logic        global_interrupt_enable_i,
   input wire logic [7:0]  irq_flag_i,
   input wire logic [7:0]  irq_enable_i,
   input wire logic        external_reset_pin_i,
   input wire logic        external_reset_en_i,
   input wire logic        brownout_reset_i,
   input wire logic        brownout_reset_en_i,
   input wire logic        por_i,
   input wire logic        crystal_osc_mode_i,
   input wire logic        two_speed_i,
   input wire logic        lp_incompatible_i,
   input wire logic        unregulated_i,
   input wire logic        cpu_clk_en_o,
   input wire logic        device_reset_o,
   input wire logic        timeout_status_flag_o,
   input wire logic        powerdown_status_flag_o,
   input wire logic        prefetch_next_o,
   input wire logic        resume_o,
   input wire logic        vector_req_o,
   input wire logic [13:0] vector_addr_o,
   input wire logic        reg_lowpower_o,
   input wire logic        sleeping_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LPC = LP_WAKE_NS / CLK_PERIOD_NS;
   logic        pend, rev, go, nop, osc, lp_seen;
   logic [11:0] wcnt;
   assign pend = |(irq_flag_i & irq_enable_i);
   assign rev = por_i | (external_reset_pin_i & external_reset_en_i)
              | (brownout_reset_i & brownout_reset_en_i);
   assign go = cpu_clk_en_o & sleep_instr_i & !rev;
   assign nop = !global_interrupt_enable_i & pend;
   assign osc = crystal_osc_mode_i & !two_speed_i;
   // Cycles spent waking; the unregulated part never pays the delay.
   always_ff @(posedge mclk_i) begin
      if (reset_i || sleeping_o)
         wcnt <= 12'h000;
      else if (!cpu_clk_en_o)
         wcnt <= wcnt + 12'h001;
   end
   always_ff @(posedge mclk_i) begin
      if (reset_i)
         lp_seen <= 1'b0;
      else if (sleeping_o)
         lp_seen <= reg_lowpower_o & !unregulated_i;
   end
   default clocking dc @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   sleep_entry_a: assert property (go && !nop |=> sleeping_o &&
      !cpu_clk_en_o && !powerdown_status_flag_o && timeout_status_flag_o)
      else $error("sleep entry state wrong");
   sleep_nop_a: assert property (go && nop |=> !sleeping_o &&
      $stable(powerdown_status_flag_o) && $stable(timeout_status_flag_o))
      else $error("sleep with pending interrupt not a no-op");
   sleep_cause_a: assert property ($rose(sleeping_o)
      |-> $past(sleep_instr_i)) else $error("sleep without instruction");
   prefetch_a: assert property (go |=> prefetch_next_o)
      else $error("no prefetch pulse");
   reset_wake_a: assert property (sleeping_o && rev
      |=> device_reset_o && !sleeping_o) else $error("reset wake wrong");
   irq_wake_a: assert property (sleeping_o && pend && !rev
      |=> !sleeping_o && !device_reset_o) else $error("irq wake wrong");
   vector_a: assert property (resume_o |=>
      vector_req_o == $past(global_interrupt_enable_i) &&
      (!vector_req_o || vector_addr_o == ISR_VECTOR))
      else $error("vector request wrong");
   wake_delay_a: assert property ($rose(cpu_clk_en_o) &&
      !device_reset_o |-> wcnt >= (osc ? 1024 : 0) + (lp_seen ? LPC : 0))
      else $error("clock restarted too early");
   fast_wake_a: assert property ($rose(cpu_clk_en_o) &&
      !device_reset_o && !osc && !lp_seen |-> wcnt <= 12'h002)
      else $error("normal wake delayed");
   resume_a: assert property ($rose(cpu_clk_en_o) &&
      !device_reset_o |-> $past(resume_o) or (##[0:2] resume_o))
      else $error("no resume pulse");
   lowpower_a: assert property (reg_lowpower_o |-> sleeping_o &&
      (unregulated_i || !lp_incompatible_i))
      else $error("regulator low power wrongly");
   cover property (go && !nop);
   cover property (go && nop);
   cover property (vector_req_o);
endmodule // swc_chk

bind swc_sleep_wake_control swc_chk #(.LP_WAKE_NS(LP_WAKE_NS)) chk_i (
   .mclk_i, .reset_i, .sleep_instr_i, .global_interrupt_enable_i,
   .irq_flag_i, .irq_enable_i, .external_reset_pin_i, .external_reset_en_i,
   .brownout_reset_i, .brownout_reset_en_i, .por_i, .crystal_osc_mode_i,
   .two_speed_i, .lp_incompatible_i, .unregulated_i, .cpu_clk_en_o,
   .device_reset_o, .timeout_status_flag_o, .powerdown_status_flag_o,
   .prefetch_next_o, .resume_o, .vector_req_o, .vector_addr_o,
   .reg_lowpower_o, .sleeping_o);

// ---- swc_core_model.sv ----
/* Behavioural processor core, interrupt sources and slow watchdog tick.
   Assumes the bench calls its tasks from one process at a time. */
module swc_core_model #(
   parameter int TICK_DIV = 4
) (
   input  wire logic       mclk_i,
   input  wire logic       tick_run_i,
   input  wire logic       powerdown_status_flag_i,
   output logic            sleep_instr_o,
   output logic            watchdog_clear_instruction_instr_o,
   output logic            global_interrupt_enable_o,
   output logic [7:0]      irq_flag_o,
   output logic [7:0]      irq_enable_o,
   output logic            wdt_tick_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int div = 0;
   initial begin
      sleep_instr_o = 1'b0;
      watchdog_clear_instruction_instr_o = 1'b0;
      global_interrupt_enable_o = 1'b0;
      irq_flag_o = 8'h00;
      irq_enable_o = 8'h00;
      wdt_tick_o = 1'b0;
   end
   always @(posedge mclk_i) begin
      div <= (div == TICK_DIV - 1) ? 0 : div + 1;
      wdt_tick_o <= tick_run_i && div == TICK_DIV - 1;
   end
   task automatic set_irq(input logic [7:0] f, input logic [7:0] e,
                          input logic g);
      @(posedge mclk_i);
      irq_flag_o <= f;
      irq_enable_o <= e;
      global_interrupt_enable_o <= g;
   endtask
   task automatic do_sleep(input logic late, output logic slept);
      @(posedge mclk_i);
      sleep_instr_o <= 1'b1;
      @(posedge mclk_i);
      sleep_instr_o <= 1'b0;
      if (late)
         irq_flag_o <= irq_enable_o;
      @(posedge mclk_i);
      slept = !powerdown_status_flag_i;
   endtask
endmodule // swc_core_model

// ---- tb_top.sv ----
/* Self-checking bench for the sleep/wake controller.
   Assumes swc_pkg, swc_chk and swc_core_model are compiled first. */
module tb_top
   import swc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LPN = 500;
   localparam int LPC = LPN / CLK_PERIOD_NS;
   localparam int TD = 4;
   logic mclk_i = 1'b0, reset_i = 1'b1, hsel_i = 1'b0, hwrite_i = 1'b0;
   logic [31:0] haddr_i = 32'h0, hwdata_i = 32'h0, hrdata_o;
   logic [1:0] htrans_i = 2'h0, wdt_mode_i = WDT_MODE_OFF;
   logic pin = 1'b0, pin_en = 1'b0, bor = 1'b0, bor_en = 1'b0, por = 1'b0;
   logic crys = 1'b0, two = 1'b0, inc = 1'b0, unreg = 1'b0, cwu = 1'b0;
   logic tick_run = 1'b0, vec_seen = 1'b0, hreadyout_o, hresp_o, tick;
   logic sleep_i, watchdog_clear_instruction_i, global_interrupt_enable, cpu_clk_en_o, device_reset_o, to, pd;
   logic prefetch_next_o, resume_o, vector_req_o, reg_lowpower_o;
   logic hfosc_keep_o, sleeping_o;
   logic [7:0] flag, en;
   logic [13:0] vector_addr_o;
   logic [5:0] cfg [7] = '{6'h00, 6'h11, 6'h18, 6'h20, 6'h24, 6'h22, 6'h30};
   logic [6:0] lpx = 7'h68;
   int lo [7] = '{1, 1024, 1, LPC, 1, 1, 1024 + LPC};
   int hi [7] = '{4, 1032, 4, LPC + 5, 4, 4, 1034 + LPC};
   int error_cnt = 0, compares = 0, cyc = 0;
   swc_sleep_wake_control #(.LP_WAKE_NS(LPN)) uut (
      .mclk_i, .reset_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
      .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
      .hreadyout_o, .hresp_o, .sleep_instr_i(sleep_i),
      .watchdog_clear_instruction_instr_i(watchdog_clear_instruction_i), .global_interrupt_enable_i(global_interrupt_enable),
      .irq_flag_i(flag), .irq_enable_i(en), .external_reset_pin_i(pin),
      .external_reset_en_i(pin_en), .brownout_reset_i(bor),
      .brownout_reset_en_i(bor_en), .por_i(por), .wdt_mode_i,
      .wdt_tick_i(tick), .crystal_osc_mode_i(crys), .two_speed_i(two),
      .lp_incompatible_i(inc), .unregulated_i(unreg),
      .cwu_uses_hfosc_i(cwu), .cpu_clk_en_o, .device_reset_o,
      .timeout_status_flag_o(to), .powerdown_status_flag_o(pd),
      .prefetch_next_o, .resume_o, .vector_req_o, .vector_addr_o,
      .reg_lowpower_o, .hfosc_keep_o, .sleeping_o);
   swc_core_model #(.TICK_DIV(TD)) core (
      .mclk_i, .tick_run_i(tick_run), .powerdown_status_flag_i(pd),
      .sleep_instr_o(sleep_i), .watchdog_clear_instruction_instr_o(watchdog_clear_instruction_i),
      .global_interrupt_enable_o(global_interrupt_enable), .irq_flag_o(flag),
      .irq_enable_o(en), .wdt_tick_o(tick));
   always #25 mclk_i = ~mclk_i;
   always @(posedge mclk_i) begin
      if (vector_req_o === 1'b1)
         vec_seen <= 1'b1;
      cyc++;
      if (cyc == 60000) begin
         error_cnt++;
         tally_and_finish();
      end
   end
   task automatic tally_and_finish();
      if (error_cnt == 0 && compares > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] ex, got);
      compares++;
      if (got !== ex) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, ex, got);
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge mclk_i);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      haddr_i <= {24'h0, a};
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      hsel_i <= 1'b0;
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      do @(posedge mclk_i); while (hreadyout_o !== 1'b1);
      rd = hrdata_o;
   endtask
   task automatic acc(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, ex, input string nm);
      logic [31:0] r;
      if (wr)
         ahb(1'b1, a, d, r);
      ahb(1'b0, a, 32'h0, r);
      chk(nm, ex, r);
      chk("response", 32'h0, hresp_o);
   endtask
   task automatic wait_clk(output int n);
      n = 0;
      while (cpu_clk_en_o !== 1'b1) begin
         @(posedge mclk_i);
         n++;
      end
   endtask
   task automatic t_regs();
      acc(1'b0, ADDR_REGCTRL, 32'h0, 32'h1, "regctrl reset");
      acc(1'b0, ADDR_WDTCTRL, 32'h0, 32'(WDT_PS_RESET) << WDT_PS_LSB,
          "wdtctrl reset");
      acc(1'b1, ADDR_REGCTRL, 32'h2, 32'h3, "regctrl mode");
      acc(1'b1, ADDR_REGCTRL, 32'h0, 32'h1, "regctrl bit0");
      acc(1'b1, ADDR_STATUS, 32'h0, 32'h13, "status");
      acc(1'b1, 8'h0c, 32'hff, 32'h0, "unmapped");
   endtask
   task automatic t_nop();
      logic s;
      core.set_irq(8'h01, 8'h01, 1'b0);
      core.do_sleep(1'b0, s);
      chk("nop slept", 32'h0, s);
      chk("nop flags", 32'h3, {pd, to});
      core.set_irq(8'h00, 8'h01, 1'b0);
   endtask
   task automatic t_modes();
      logic s;
      int n;
      for (int i = 0; i < 7; i++) begin
         acc(1'b1, ADDR_REGCTRL, {cfg[i][5], 1'b1}, {cfg[i][5], 1'b1}, "rc");
         {crys, two, inc, unreg, cwu} <= cfg[i][4:0];
         vec_seen <= 1'b0;
         core.set_irq(8'h00, 8'h01, i[0]);
         core.do_sleep(1'b0, s);
         chk("slept", 32'h1, s);
         chk("sleep flags", 32'h1, {pd, to});
         chk("low power", lpx[i], reg_lowpower_o);
         chk("hf osc", cfg[i][0], hfosc_keep_o);
         core.set_irq(8'h02, 8'h01, i[0]);
         repeat (4) @(posedge mclk_i);
         chk("asleep", 32'h1, sleeping_o);
         core.set_irq(8'h03, 8'h03, i[0]);
         wait_clk(n);
         chk("wake time", 32'h1, n >= lo[i] && n <= hi[i]);
         repeat (3) @(posedge mclk_i);
         chk("vector", i[0], vec_seen);
         core.set_irq(8'h00, 8'h01, 1'b0);
      end
      {crys, two, inc, unreg, cwu} <= 5'h00;
   endtask
   task automatic t_resets();
      logic s;
      logic [4:0] evt [4] = '{5'h10, 5'h18, 5'h06, 5'h01};
      for (int k = 0; k < 4; k++) begin
         core.set_irq(8'h00, 8'h01, 1'b0);
         core.do_sleep(1'b0, s);
         {pin, pin_en, bor, bor_en, por} <= evt[k];
         @(posedge mclk_i);
         {pin, pin_en, bor, bor_en, por} <= 5'h00;
         @(posedge mclk_i);
         chk("reset out", k != 0, device_reset_o);
         chk("reset wake", k == 0, sleeping_o);
         core.set_irq(8'h01, 8'h01, 1'b0);
         // The first pass wakes through the low-power delay; let it end.
         repeat (12) @(posedge mclk_i);
         chk("reset flags", (k != 0) ? 3 : 1, {pd, to});
      end
   endtask
   task automatic t_wdt();
      logic [31:0] r;
      logic s;
      int n;
      ahb(1'b1, ADDR_WDTCTRL, 32'h0, r);
      wdt_mode_i <= WDT_MODE_ON;
      tick_run <= 1'b1;
      core.set_irq(8'h00, 8'h00, 1'b0);
      core.do_sleep(1'b0, s);
      wait_clk(n);
      chk("wdt sleep time", 32'h1,
          n >= 32 * TD - 2 && n <= 32 * TD + 1);
      chk("wdt wake flags", 32'h0, {pd, to});
      chk("wdt no reset", 32'h0, device_reset_o);
      n = 0;
      while (device_reset_o !== 1'b1 && n < 1000) begin
         @(posedge mclk_i);
         n++;
      end
      chk("wdt period", 32'h1, n >= 32 * TD - 4 && n <= 32 * TD + 4);
      chk("wdt reset flags", 32'h2, {pd, to});
      wdt_mode_i <= WDT_MODE_NOSLP;
      core.do_sleep(1'b0, s);
      repeat (140) @(posedge mclk_i);
      chk("wdt off in sleep", 32'h1, sleeping_o);
      core.set_irq(8'h01, 8'h01, 1'b0);
      wait_clk(n);
      wdt_mode_i <= WDT_MODE_OFF;
      tick_run <= 1'b0;
   endtask
   task automatic t_late();
      logic s;
      int n;
      core.set_irq(8'h00, 8'h01, 1'b0);
      core.do_sleep(1'b1, s);
      chk("late slept", 32'h1, s);
      wait_clk(n);
      chk("late wake", 32'h1, n <= 3);
      chk("late flags", 32'h1, {pd, to});
   endtask
   initial begin
      repeat (12) @(posedge mclk_i);
      reset_i <= 1'b0;
      t_regs();
      t_nop();
      t_modes();
      t_resets();
      t_wdt();
      t_late();
      tally_and_finish();
   end
endmodule // tb_top
